//--- core/breaker_pkg.sv
// Shared constants and types for breaker control and trip-path supervision
package breaker_pkg;
	// Register byte offsets
	localparam logic [7:0] off_ctrl     = 8'h00; // Control and command bits
	localparam logic [7:0] off_status   = 8'h04; // Live state and alarms
	localparam logic [7:0] off_close_dl = 8'h08; // Manual close delay, ticks
	localparam logic [7:0] off_close_pw = 8'h0c; // Close pulse width, ticks
	localparam logic [7:0] off_trip_pw  = 8'h10; // Trip pulse width, ticks
	localparam logic [7:0] off_ready_to = 8'h14; // Breaker-ready timeout, ticks
	localparam logic [7:0] off_sync_to  = 8'h18; // Sync-check timeout, ticks
	localparam logic [7:0] off_blk_time = 8'h1c; // Reclose block time, ticks
	// Control register field positions
	localparam int ctl_src_lo   = 0;  // Position source, two bits
	localparam int ctl_sync_en  = 2;  // Sync supervision enable
	localparam int ctl_ready_en = 3;  // Ready check enable
	localparam int ctl_clr_ui   = 4;  // Lockout cleared by command only
	localparam int ctl_two_in   = 5;  // Two-input monitor variant
	localparam int ctl_close    = 8;  // Write 1: manual close request
	localparam int ctl_trip     = 9;  // Write 1: manual trip request
	localparam int ctl_lo_clr   = 10; // Write 1: lockout reset command
	// Position source encodings
	localparam logic [1:0] src_none = 2'h0;
	localparam logic [1:0] src_cl   = 2'h1;
	localparam logic [1:0] src_op   = 2'h2;
	localparam logic [1:0] src_both = 2'h3;
	// Reset values of settings, in 10 ms ticks
	localparam logic [5:0]  rst_ctrl     = 6'h00;
	localparam logic [15:0] rst_close_dl = 16'h03e8; // 10 s
	localparam logic [15:0] rst_close_pw = 16'h0032; // 0.5 s
	localparam logic [15:0] rst_trip_pw  = 16'h0032; // 0.5 s
	localparam logic [15:0] rst_ready_to = 16'h01f4; // 5 s
	localparam logic [15:0] rst_sync_to  = 16'h01f4; // 5 s
	localparam logic [15:0] rst_blk_time = 16'h01f4; // 5 s
	// Timebase
	localparam int clk_mhz     = 200;
	localparam int tick_ms     = 10;
	localparam int tick_cycles = tick_ms * 1000 * clk_mhz; // 2,000,000
	// Trip-path monitor times
	localparam int dropoff_ms     = 400;
	localparam int pickup_ms      = 50;
	localparam int dropoff_cycles = dropoff_ms * 1000 * clk_mhz;
	localparam int pickup_cycles  = pickup_ms * 1000 * clk_mhz;
	// Monitor inputs carried together
	typedef struct packed {
		logic mon_a; // Monitor input one (follows closed contact in two-input use)
		logic mon_b; // Monitor input two (follows open contact)
	} mon_in_s;
	// Breaker-side contacts
	typedef struct packed {
		logic closed_contact; // breaker_closed_contact
		logic open_contact;   // breaker_open_contact
		logic ready;          // Breaker-ready isolated input
		logic sync_ok;        // Synchronism condition satisfied
	} breaker_in_s;
endpackage

//--- core/trip_path_monitor.sv
// Trip-path monitor: drop-off delay and power-up pick-up delay
`timescale 1ns/1ps
module trip_path_monitor #(
	parameter int dropoff_n = breaker_pkg::dropoff_cycles,
	parameter int pickup_n  = breaker_pkg::pickup_cycles
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  two_in,
	input  wire breaker_pkg::mon_in_s  mon,
	output logic                       alarm_contact_open,
	output logic                       fail_ind
);
	logic        energised;  // Any monitored path carries current
	logic [31:0] drop_cnt;   // Counts de-energised time
	logic        ddo_active; // Drop-off timer output
	logic [31:0] pick_cnt;   // Counts failure persistence
	// Two-input variant needs both off to call a failure
	assign energised = two_in ? (mon.mon_a | mon.mon_b) : mon.mon_a;

	// Drop-off timer: sets at once, releases after the full de-energised time
	always_ff @(posedge clk) begin
		if (!nrst) begin
			drop_cnt   <= '0;
			ddo_active <= 1'b0;
		end else if (energised) begin
			drop_cnt   <= '0;
			ddo_active <= 1'b1;
		end else if (ddo_active) begin
			if (drop_cnt == 32'(dropoff_n - 1)) begin
				ddo_active <= 1'b0;
			end else begin
				drop_cnt <= drop_cnt + 32'h1;
			end
		end
	end

	// Normally closed contact opens while healthy
	always_ff @(posedge clk) begin
		if (!nrst) alarm_contact_open <= 1'b0;
		else alarm_contact_open <= ddo_active;
	end

	// Pick-up delay hides the failure while powering up
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pick_cnt <= '0;
			fail_ind <= 1'b0;
		end else if (ddo_active) begin
			pick_cnt <= '0;
			fail_ind <= 1'b0;
		end else if (pick_cnt == 32'(pickup_n - 1)) begin
			fail_ind <= 1'b1;
		end else begin
			pick_cnt <= pick_cnt + 32'h1;
		end
	end

	chk_dropoff_hold: assert property (@(posedge clk) disable iff (!nrst)
		energised |=> ddo_active) else $error("drop-off timer not set");
	chk_led_cleared: assert property (@(posedge clk) disable iff (!nrst)
		ddo_active |=> !fail_ind) else $error("failure shown while healthy");
endmodule

//--- core/breaker_control.sv
// Breaker control with AHB-Lite register access and trip-path monitor
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module breaker_control #(
	parameter int tick_n    = breaker_pkg::tick_cycles,
	parameter int dropoff_n = breaker_pkg::dropoff_cycles,
	parameter int pickup_n  = breaker_pkg::pickup_cycles
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic [31:0]                   hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire breaker_pkg::breaker_in_s brk,
	input  wire breaker_pkg::mon_in_s     mon,
	input  wire logic                     prot_trip,
	input  wire logic                     ext_lockout,
	input  wire logic                     auto_close_req,
	output logic                          trip_coil,
	output logic                          close_coil,
	output logic                          lockout,
	output logic                          lockout_alarm,
	output logic                          open_failure_alarm,
	output logic                          shut_failure_alarm,
	output logic                          reclose_block,
	output logic                          tp_alarm_contact_open,
	output logic                          tp_fail_ind
);
	typedef enum logic [2:0] {st_idle, st_delay, st_wait, st_close, st_trip} ctl_e;
	ctl_e        state;       // Command sequencer state
	logic [5:0]  ctrl;        // Settings bits
	logic [15:0] close_dl;    // Manual close delay
	logic [15:0] close_pw;    // Close pulse width
	logic [15:0] trip_pw;     // Trip pulse width
	logic [15:0] ready_to;    // Ready timeout
	logic [15:0] sync_to;     // Sync timeout
	logic [15:0] blk_time;    // Reclose block time
	logic [15:0] tcnt;        // Sequencer tick count
	logic [15:0] wcnt;        // Ready/sync wait tick count
	logic [15:0] bcnt;        // Reclose block tick count
	logic [31:0] div;         // Tick divider
	logic        tick;        // One pulse per 10 ms
	logic        wr_ph;       // Pending write data phase
	logic [7:0]  wr_addr;     // Latched write address
	logic        is_closed;   // Decoded breaker position
	logic        is_open;
	logic        pos_known;   // Position source not none
	logic        close_cmd;   // Close command strobe from software
	logic        trip_cmd;    // Trip command strobe
	logic        clr_cmd;     // Lockout reset command strobe
	logic        fail_close;  // Checks failed this cycle

	// Position decode per selected source; with both selected the contacts must agree
	function automatic logic [1:0] decode_pos(input logic [1:0] src, input logic c,
		input logic o);
		case (src)
			breaker_pkg::src_cl:   decode_pos = {c, !c};
			breaker_pkg::src_op:   decode_pos = {!o, o};
			breaker_pkg::src_both: decode_pos = {c & !o, o & !c};
			default:               decode_pos = 2'b00;
		endcase
	endfunction
	assign {is_closed, is_open} = decode_pos(ctrl[1:0], brk.closed_contact, brk.open_contact);
	assign pos_known = ctrl[1:0] != breaker_pkg::src_none;

	// Tick divider; long intervals count 10 ms ticks
	always_ff @(posedge clk) begin
		if (!nrst || div == 32'(tick_n - 1)) div <= '0;
		else div <= div + 32'h1;
	end
	assign tick = div == 32'(tick_n - 1);

	// Bus slave: zero wait states, latch write address for data phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ph   <= 1'b0;
			wr_addr <= '0;
		end else if (hready) begin
			wr_ph   <= hsel & htrans[1] & hwrite;
			wr_addr <= haddr[7:0];
		end
	end
	assign close_cmd = wr_ph && wr_addr == breaker_pkg::off_ctrl && hwdata[breaker_pkg::ctl_close];
	assign trip_cmd  = wr_ph && wr_addr == breaker_pkg::off_ctrl && hwdata[breaker_pkg::ctl_trip];
	assign clr_cmd   = wr_ph && wr_addr == breaker_pkg::off_ctrl
		&& hwdata[breaker_pkg::ctl_lo_clr];

	// Settings registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl     <= breaker_pkg::rst_ctrl;
			close_dl <= breaker_pkg::rst_close_dl;
			close_pw <= breaker_pkg::rst_close_pw;
			trip_pw  <= breaker_pkg::rst_trip_pw;
			ready_to <= breaker_pkg::rst_ready_to;
			sync_to  <= breaker_pkg::rst_sync_to;
			blk_time <= breaker_pkg::rst_blk_time;
		end else if (wr_ph) begin
			case (wr_addr)
				breaker_pkg::off_ctrl:     ctrl     <= hwdata[5:0];
				breaker_pkg::off_close_dl: close_dl <= hwdata[15:0];
				breaker_pkg::off_close_pw: close_pw <= hwdata[15:0];
				breaker_pkg::off_trip_pw:  trip_pw  <= hwdata[15:0];
				breaker_pkg::off_ready_to: ready_to <= hwdata[15:0];
				breaker_pkg::off_sync_to:  sync_to  <= hwdata[15:0];
				breaker_pkg::off_blk_time: blk_time <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// Read data, registered; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				breaker_pkg::off_ctrl:     hrdata <= {26'h0, ctrl};
				breaker_pkg::off_status:   hrdata <= {22'h0, tp_fail_ind, reclose_block,
					shut_failure_alarm, open_failure_alarm, lockout_alarm, lockout,
					close_coil, trip_coil, is_open, is_closed};
				breaker_pkg::off_close_dl: hrdata <= {16'h0, close_dl};
				breaker_pkg::off_close_pw: hrdata <= {16'h0, close_pw};
				breaker_pkg::off_trip_pw:  hrdata <= {16'h0, trip_pw};
				breaker_pkg::off_ready_to: hrdata <= {16'h0, ready_to};
				breaker_pkg::off_sync_to:  hrdata <= {16'h0, sync_to};
				breaker_pkg::off_blk_time: hrdata <= {16'h0, blk_time};
				default:                   hrdata <= '0;
			endcase
		end
	end

	// Ready once out of reset, always OKAY
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Manual windows failed: only manual closes use these timers
	assign fail_close = state == st_wait && tick &&
		((ctrl[breaker_pkg::ctl_sync_en] && !brk.sync_ok && wcnt >= sync_to) ||
		 (ctrl[breaker_pkg::ctl_ready_en] && !brk.ready && wcnt >= ready_to));

	// Command sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state      <= st_idle;
			tcnt       <= '0;
			wcnt       <= '0;
			trip_coil  <= 1'b0;
			close_coil <= 1'b0;
		end else if (prot_trip && state != st_trip) begin
			state      <= st_idle;
			close_coil <= 1'b0;
		end else begin
			case (state)
				st_idle: begin
					tcnt <= '0;
					wcnt <= '0;
					if (trip_cmd && pos_known && is_closed) begin
						state     <= st_trip;
						trip_coil <= 1'b1;
					end else if (close_cmd && pos_known && is_open && !lockout) begin
						state <= st_delay;
					end else if (auto_close_req && pos_known && is_open && !lockout) begin
						state      <= st_close;
						close_coil <= 1'b1;
					end
				end
				st_delay: begin
					if (tick) tcnt <= tcnt + 16'h1;
					// Ends only on a tick, so the delay never falls short of its setting
					if (tick && tcnt >= close_dl) begin
						state <= st_wait;
						tcnt  <= '0;
					end
				end
				st_wait: begin
					if (tick) wcnt <= wcnt + 16'h1;
					if (fail_close || lockout) begin
						state <= st_idle;
					end else if ((!ctrl[breaker_pkg::ctl_sync_en] || brk.sync_ok) &&
						(!ctrl[breaker_pkg::ctl_ready_en] || brk.ready)) begin
						state      <= st_close;
						close_coil <= 1'b1;
					end
				end
				st_close: begin
					if (tick) tcnt <= tcnt + 16'h1;
					if (ctrl[breaker_pkg::ctl_sync_en] && !brk.sync_ok) close_coil <= 1'b0;
					if (tick && tcnt >= close_pw) begin
						state      <= st_idle;
						close_coil <= 1'b0;
					end
				end
				st_trip: begin
					if (tick) tcnt <= tcnt + 16'h1;
					if (tick && tcnt >= trip_pw) begin
						state     <= st_idle;
						trip_coil <= 1'b0;
					end
				end
				default: state <= st_idle;
			endcase
		end
	end

	// Failure alarms at the last edge of the pulse; cleared only by lockout reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			open_failure_alarm <= 1'b0;
			shut_failure_alarm <= 1'b0;
		end else begin
			if (state == st_trip && tick && tcnt >= trip_pw && !is_open)
				open_failure_alarm <= 1'b1;
			else if (clr_cmd) open_failure_alarm <= 1'b0;
			if (state == st_close && tick && tcnt >= close_pw && !is_closed)
				shut_failure_alarm <= 1'b1;
			else if (clr_cmd) shut_failure_alarm <= 1'b0;
		end
	end

	// Lockout: set wins over clear; reset by command or by closing
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lockout       <= 1'b0;
			lockout_alarm <= 1'b0;
		end else if (fail_close || ext_lockout) begin
			lockout       <= 1'b1;
			lockout_alarm <= 1'b1;
		end else if (clr_cmd || (!ctrl[breaker_pkg::ctl_clr_ui] && is_closed && close_coil)) begin
			lockout       <= 1'b0;
			lockout_alarm <= 1'b0;
		end
	end

	// Autoreclose block after every close pulse, manual or automatic
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bcnt          <= '0;
			reclose_block <= 1'b0;
		end else if (state == st_close && close_coil) begin
			bcnt          <= '0;
			reclose_block <= 1'b1;
		end else if (reclose_block && tick) begin
			if (bcnt >= blk_time) reclose_block <= 1'b0;
			else bcnt <= bcnt + 16'h1;
		end
	end

	trip_path_monitor #(.dropoff_n(dropoff_n), .pickup_n(pickup_n)) u_tpm (
		.clk                (clk),
		.nrst               (nrst),
		.two_in             (ctrl[breaker_pkg::ctl_two_in]),
		.mon                (mon),
		.alarm_contact_open (tp_alarm_contact_open),
		.fail_ind           (tp_fail_ind)
	);

	sequence s_prot;
		prot_trip && state != st_trip;
	endsequence
	chk_trip_priority: assert property (@(posedge clk) disable iff (!nrst)
		s_prot |=> !close_coil) else $error("close kept during protection trip");
	chk_sync_gate: assert property (@(posedge clk) disable iff (!nrst)
		$rose(close_coil) && state == st_close && $past(state) == st_wait
		|-> !ctrl[breaker_pkg::ctl_sync_en] || $past(brk.sync_ok))
		else $error("close without synchronism");
	chk_lock_on_fail: assert property (@(posedge clk) disable iff (!nrst)
		fail_close |=> lockout && lockout_alarm) else $error("no lockout on failure");
	chk_no_close_lock: assert property (@(posedge clk) disable iff (!nrst)
		fail_close |=> state == st_idle && !close_coil) else $error("close after fail");
	chk_source_none: assert property (@(posedge clk) disable iff (!nrst)
		!pos_known && state == st_idle |=> !trip_coil && !close_coil)
		else $error("control with no source");
	chk_trip_closed: assert property (@(posedge clk) disable iff (!nrst)
		$rose(trip_coil) |-> $past(is_closed)) else $error("trip while not closed");
	chk_lock_holds: assert property (@(posedge clk) disable iff (!nrst)
		lockout && !clr_cmd && !(is_closed && close_coil) |=> lockout)
		else $error("lockout dropped");
	chk_block_set: assert property (@(posedge clk) disable iff (!nrst)
		state == st_close && close_coil |=> reclose_block) else $error("no reclose block");
endmodule

//--- sim/breaker_model.sv
// Breaker model: auxiliary contacts, readiness, sync status and trip-path feed
`timescale 1ns/1ps
module breaker_model (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 trip_coil,
	input  wire logic                 close_coil,
	input  wire logic                 stuck,
	input  wire logic                 ready,
	input  wire logic                 sync_ok,
	input  wire logic                 tp_ok,
	output breaker_pkg::breaker_in_s  brk,
	output breaker_pkg::mon_in_s      mon
);
	logic       is_shut; // Main contact position
	logic [2:0] run;     // Cycles the active coil has been held
	// The mechanism moves only after a coil is held a few cycles;
	// a stuck breaker ignores both coils
	always_ff @(posedge clk) begin
		if (!nrst) begin
			run <= 3'h0;
			is_shut <= 1'b0;
		end else begin
			run <= (trip_coil | close_coil) ? run + 3'h1 : 3'h0;
			if (!stuck && run == 3'h4) begin
				is_shut <= close_coil & ~trip_coil;
			end
		end
	end
	// Closed contact follows the position, open contact is its opposite
	assign brk = {is_shut, ~is_shut, ready, sync_ok};
	// Supervision current reaches the input matching the position
	assign mon = {tp_ok & is_shut, tp_ok & ~is_shut};
endmodule

//--- sim/breaker_control_tb_top.sv
// Self-checking bench for breaker control and trip-path supervision
`timescale 1ns/1ps
module breaker_control_tb_top;
	localparam int tk = 10; // Cycles per tick in this run
	localparam logic [15:0] dfl [6] = '{breaker_pkg::rst_close_dl, breaker_pkg::rst_close_pw,
		breaker_pkg::rst_trip_pw, breaker_pkg::rst_ready_to, breaker_pkg::rst_sync_to,
		breaker_pkg::rst_blk_time};
	logic                      clk, nrst, hsel, hwrite, hreadyout, hresp;
	logic [31:0]               haddr, hwdata, hrdata, q, cfg;
	logic [1:0]                htrans;
	logic [2:0]                hsize;
	logic                      prot_trip, stuck, ready, sync, tp_ok, ext_lo, auto_cl;
	logic                      trip_coil, close_coil, lockout, lockout_alarm;
	logic                      open_failure_alarm, shut_failure_alarm, reclose_block;
	logic                      tp_alarm_contact_open, tp_fail_ind;
	breaker_pkg::breaker_in_s  brk;
	breaker_pkg::mon_in_s      mon;
	int                        miscompares, n_tests, n;

	breaker_control #(.tick_n(tk), .dropoff_n(80), .pickup_n(10)) dut (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .brk(brk), .mon(mon),
		.prot_trip(prot_trip), .ext_lockout(ext_lo), .auto_close_req(auto_cl),
		.trip_coil(trip_coil), .close_coil(close_coil), .lockout(lockout),
		.lockout_alarm(lockout_alarm), .open_failure_alarm(open_failure_alarm),
		.shut_failure_alarm(shut_failure_alarm), .reclose_block(reclose_block),
		.tp_alarm_contact_open(tp_alarm_contact_open), .tp_fail_ind(tp_fail_ind));

	breaker_model far (.clk(clk), .nrst(nrst), .trip_coil(trip_coil),
		.close_coil(close_coil), .stuck(stuck), .ready(ready), .sync_ok(sync),
		.tp_ok(tp_ok), .brk(brk), .mon(mon));

	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Value comparison with case equality
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cycle count comparison against a window
	task automatic chk_rng(input int v, input int lo, input int hi);
		n_tests++;
		if (v < lo || v > hi) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask

	// One AHB-Lite single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	// Control write with one command strobe on top of the held settings
	task automatic cmd(input int b);
		bus(1'b1, breaker_pkg::off_ctrl, cfg | (32'h1 << b));
	endtask

	// Output selector so one wait task serves seven of the outputs
	function automatic logic pick(input int k);
		case (k)
			0: return close_coil;
			1: return trip_coil;
			2: return lockout;
			3: return shut_failure_alarm;
			4: return reclose_block;
			5: return tp_fail_ind;
			default: return tp_alarm_contact_open;
		endcase
	endfunction

	// Bounded wait; n equals lim when the level never came
	task automatic wait_sig(input int k, input logic v, input int lim);
		n = 0;
		while (pick(k) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	// Defaults, unmapped place, then short settings for the run
	task automatic t_regs;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, breaker_pkg::off_close_dl + 8'(4 * i), 32'h0);
			chk(q, {16'h0, dfl[i]});
		end
		bus(1'b1, 8'h24, 32'hffff);
		bus(1'b0, 8'h24, 32'h0);
		chk(q, 32'h0);
		chk(hresp, 1'b0);
		bus(1'b1, breaker_pkg::off_close_dl, 32'h2);
		bus(1'b1, breaker_pkg::off_close_pw, 32'h3);
		bus(1'b1, breaker_pkg::off_trip_pw, 32'h3);
		bus(1'b1, breaker_pkg::off_ready_to, 32'h4);
		bus(1'b1, breaker_pkg::off_sync_to, 32'h4);
		bus(1'b1, breaker_pkg::off_blk_time, 32'h5);
	endtask

	// Manual close and trip with their gates, delays and widths
	task automatic t_close_trip;
		cfg = 32'h0;
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 60);
		chk_rng(n, 60, 60);
		auto_cl <= 1'b1;
		@(posedge clk);
		auto_cl <= 1'b0;
		wait_sig(0, 1'b1, 20);
		chk_rng(n, 20, 20);
		cfg = {30'h0, breaker_pkg::src_both};
		cmd(breaker_pkg::ctl_trip);
		wait_sig(1, 1'b1, 40);
		chk_rng(n, 40, 40);
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 60);
		chk_rng(n, 2 * tk - 2, 3 * tk + 3);
		wait_sig(0, 1'b0, 60);
		chk_rng(n, 3 * tk - 2, 4 * tk + 3);
		chk(reclose_block, 1'b1);
		bus(1'b0, breaker_pkg::off_status, 32'h0);
		chk(q[1:0], 2'h1);
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 40);
		chk_rng(n, 40, 40);
		wait_sig(4, 1'b0, 90);
		chk_rng(n, 1, 7 * tk);
		cmd(breaker_pkg::ctl_trip);
		wait_sig(1, 1'b1, 10);
		chk_rng(n, 0, 3);
		wait_sig(1, 1'b0, 60);
		chk_rng(n, 3 * tk - 2, 4 * tk + 3);
		bus(1'b0, breaker_pkg::off_status, 32'h0);
		chk(q[1:0], 2'h2);
	endtask

	// A breaker that ignores its close coil, then a lockout reset
	task automatic t_fail;
		stuck <= 1'b1;
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 60);
		wait_sig(0, 1'b0, 60);
		wait_sig(3, 1'b1, 30);
		chk_rng(n, 0, 2 * tk);
		stuck <= 1'b0;
		cmd(breaker_pkg::ctl_lo_clr);
		@(posedge clk);
		chk(shut_failure_alarm, 1'b0);
		// Close for real, then a trip that the breaker ignores
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 60);
		wait_sig(0, 1'b0, 60);
		stuck <= 1'b1;
		cmd(breaker_pkg::ctl_trip);
		wait_sig(1, 1'b1, 10);
		wait_sig(1, 1'b0, 60);
		chk(open_failure_alarm, 1'b1);
		stuck <= 1'b0;
		cmd(breaker_pkg::ctl_lo_clr);
		@(posedge clk);
		chk(open_failure_alarm, 1'b0);
		// Leave the breaker open for the window scenarios
		cmd(breaker_pkg::ctl_trip);
		wait_sig(1, 1'b1, 10);
		wait_sig(1, 1'b0, 60);
	endtask

	// Expired sync or ready window locks out and stays locked until reset
	task automatic t_windows(input int en);
		cfg = {30'h0, breaker_pkg::src_both} | (32'h1 << en);
		sync <= 1'b0;
		ready <= 1'b0;
		cmd(breaker_pkg::ctl_close);
		wait_sig(2, 1'b1, 120);
		chk_rng(n, 6 * tk, 8 * tk + 3);
		chk(lockout_alarm, 1'b1);
		bus(1'b0, breaker_pkg::off_status, 32'h0);
		chk(q[5:0], 6'h32);
		sync <= 1'b1;
		ready <= 1'b1;
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 60);
		chk_rng(n, 60, 60);
		cmd(breaker_pkg::ctl_lo_clr);
		wait_sig(2, 1'b0, 4);
		chk_rng(n, 0, 3);
	endtask

	// Sync present: close goes out; protection trip then cuts it
	task automatic t_prot;
		sync <= 1'b1;
		cfg = {30'h0, breaker_pkg::src_both} | (32'h1 << breaker_pkg::ctl_sync_en);
		cmd(breaker_pkg::ctl_close);
		wait_sig(0, 1'b1, 120);
		chk_rng(n, 2 * tk - 2, 7 * tk);
		prot_trip <= 1'b1;
		repeat (2) @(posedge clk);
		chk(close_coil, 1'b0);
		prot_trip <= 1'b0;
		// Outside lockout source, cleared by the same reset command
		ext_lo <= 1'b1;
		@(posedge clk);
		ext_lo <= 1'b0;
		@(posedge clk);
		chk(lockout, 1'b1);
		cmd(breaker_pkg::ctl_lo_clr);
		wait_sig(2, 1'b0, 4);
		chk_rng(n, 0, 3);
	endtask

	// Two-input trip-path supervision with the breaker open
	task automatic t_monitor;
		cfg = {30'h0, breaker_pkg::src_both} | (32'h1 << breaker_pkg::ctl_two_in);
		cmd(breaker_pkg::ctl_lo_clr);
		repeat (5) @(posedge clk);
		chk(tp_alarm_contact_open, 1'b1);
		chk(tp_fail_ind, 1'b0);
		tp_ok <= 1'b0;
		wait_sig(6, 1'b0, 120);
		chk_rng(n, 78, 85);
		wait_sig(5, 1'b1, 30);
		chk_rng(n, 8, 13);
		tp_ok <= 1'b1;
		wait_sig(6, 1'b1, 10);
		chk_rng(n, 0, 3);
		chk(tp_fail_ind, 1'b0);
	endtask

	// Verdict and end of run
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs about a thousand cycles
	initial begin
		#200000;
		miscompares++;
		final_report;
	end

	// Main sequence
	initial begin
		{nrst, hsel, hwrite, prot_trip, stuck, ready, sync} = 7'h0;
		tp_ok = 1'b1;
		ext_lo = 1'b0;
		auto_cl = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		cfg = 32'h0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs;
		t_close_trip;
		t_fail;
		t_windows(breaker_pkg::ctl_sync_en);
		t_windows(breaker_pkg::ctl_ready_en);
		t_prot;
		t_monitor;
		final_report;
	end
endmodule
